/* File: rtl/adc_readout_params.svh */
`ifndef ADC_READOUT_PARAMS_SVH
`define ADC_READOUT_PARAMS_SVH

// result width and sampled level width
`define ARO_RES_W 16
`define ARO_LEVEL_W 18
// serial clock falls after select that enable the output
`define ARO_ENABLE_FALL 5'h05
// saturation value of the fall counter
`define ARO_FALL_MAX 5'h1f
// sys_clk cycles per internal conversion step
`define ARO_CONV_DIV 2
// depth of the sample buffer
`define ARO_FIFO_DEPTH 8

`endif

/* File: rtl/adc_readout_pkg.sv */
package adc_readout_pkg;
	// converter core power state
	typedef enum logic {
		CONV_SLEEP,
		CONV_RUN
	} conv_state_e;
endpackage

/* File: rtl/sample_fifo.sv */
`timescale 1ns/1ps
// synchronous fifo with valid and ready on both sides
module sample_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// pointer wrap relies on a power of two depth
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("sample_fifo depth must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;    // storage words
		logic [AW-1:0]               wr;     // write pointer
		logic [AW-1:0]               rd;     // read pointer
		logic [AW:0]                 count;  // words held
	} fifo_s;

	fifo_s st;       // registered state
	fifo_s next_st;  // next state
	logic  push;     // word accepted
	logic  pop;      // word handed out

	// honest flags straight from the count
	assign in_ready  = (st.count != DEPTH[AW:0]);
	assign out_valid = (st.count != '0);
	assign out_data  = st.mem[st.rd];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// next state
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wr] = in_data;
			next_st.wr         = st.wr + 1'b1;
		end
		if (pop) begin
			next_st.rd = st.rd + 1'b1;
		end
		if (push && !pop) begin
			next_st.count = st.count + 1'b1;
		end else if (pop && !push) begin
			next_st.count = st.count - 1'b1;
		end
	end

	// state register
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

/* File: rtl/adc_serial_result_readout.sv */
// What this block does
// - select falling edge samples, starts conversion, transfer
// - output enabled low at fifth clock fall
// - result bits follow msb first, per fall
// - each bit stands across both clock edges
// - converter sleeps by itself after each conversion
// - output changes only on host serial clock falls and on select edges
// - straight binary, clamps to all ones, zeros
// - transfer carries this select's own conversion
// - sixteen binary trial steps from msb down
`timescale 1ns/1ps
`include "adc_readout_params.svh"

module adc_serial_result_readout #(
	parameter int RES_W      = `ARO_RES_W,
	parameter int LEVEL_W    = `ARO_LEVEL_W,
	parameter int CONV_DIV   = `ARO_CONV_DIV,
	parameter int FIFO_DEPTH = `ARO_FIFO_DEPTH
) (
	input  wire logic               sys_clk,
	input  wire logic               reset,
	input  wire logic               cs_n_pin,
	input  wire logic               serial_shift_clock_in,
	output logic                    serial_data_out,
	output logic                    serial_data_oe,
	input  wire logic [LEVEL_W-1:0] level_data,
	input  wire logic               level_valid,
	output logic                    level_ready,
	output logic                    low_power
);
	////////////////////////////////////////////////////////////////////////
	// parameter checks

	// the level needs a sign bit and one overrange bit above the result
	if (RES_W < 2 || RES_W > 30 || LEVEL_W < RES_W + 2) begin : g_bad_width
		$error("adc_serial_result_readout widths out of range");
	end
	// the conversion length check below needs a window of at most 1000 cycles
	if (CONV_DIV < 1 || CONV_DIV > 255 || RES_W * CONV_DIV > 1000) begin : g_bad_div
		$error("adc_serial_result_readout conversion divider out of range");
	end

	localparam int BW = $clog2(RES_W);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic                      cs_s1;   // select sync, first stage
		logic                      cs_s2;   // select sync, second stage
		logic                      cs_s3;   // select, delayed for edges
		logic                      sck_s1;  // serial clock sync, first stage
		logic                      sck_s2;  // serial clock sync, second stage
		logic                      sck_s3;  // serial clock, delayed for edges
		adc_readout_pkg::conv_state_e conv; // converter power state
		logic [7:0]                div;     // conversion step divider
		logic [BW-1:0]             bit_idx; // trial bit under test
		logic [RES_W-1:0]          result;  // successive approximation value
		logic signed [LEVEL_W-1:0] sample;  // held input level
		logic [4:0]                falls;   // serial clock falls this frame
		logic [RES_W-1:0]          shift;   // outgoing result bits
		logic                      dout;    // serial data level
		logic                      oe;      // serial data driven
	} readout_s;

	// clock stages start at the idle high level, so no false edge follows reset
	localparam readout_s ST_RESET = '{
		cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1,
		sck_s1: 1'b1, sck_s2: 1'b1, sck_s3: 1'b1,
		conv: adc_readout_pkg::CONV_SLEEP,
		div: 8'h00, bit_idx: '0, result: '0, sample: '0,
		falls: 5'h00, shift: '0, dout: 1'b0, oe: 1'b0
	};

	readout_s               st;         // registered state
	readout_s               next_st;    // next state
	logic                   cs_fall;    // select went low
	logic                   cs_low;     // select held low
	logic                   sck_fall;   // serial clock fell
	logic                   sck_rise;   // serial clock rose
	logic                   conv_tick;  // one conversion step
	logic [LEVEL_W-1:0]     fifo_data;  // buffered level
	logic                   fifo_valid; // buffered level present
	logic                   fifo_pop;   // take a level

	////////////////////////////////////////////////////////////////////////
	// sample buffer

	// levels wait here; only a select fall drains one, so the buffer
	// really fills and level_ready stalls the source
	sample_fifo #(
		.WIDTH (LEVEL_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.in_data   (level_data),
		.in_valid  (level_valid),
		.in_ready  (level_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// one trial step: keep the bit if the trial does not exceed the level
	function automatic logic [RES_W-1:0] sar_step(
		input logic [RES_W-1:0]          res,
		input logic [BW-1:0]             idx,
		input logic signed [LEVEL_W-1:0] lvl
	);
		logic [RES_W-1:0]          trial;
		logic signed [LEVEL_W-1:0] wide;
		trial = res | (RES_W'(1) << idx);
		wide  = $signed({{(LEVEL_W - RES_W){1'b0}}, trial});
		return (wide <= lvl) ? trial : res;
	endfunction

	// edges only from the second and third stages, never the first
	assign cs_fall   = !st.cs_s2 && st.cs_s3;
	assign cs_low    = !st.cs_s2;
	assign sck_fall  = !st.sck_s2 && st.sck_s3;
	assign sck_rise  = st.sck_s2 && !st.sck_s3;
	assign conv_tick = (st.conv == adc_readout_pkg::CONV_RUN)
		&& (st.div == 8'(CONV_DIV - 1));
	assign fifo_pop  = cs_fall;

	assign serial_data_out = st.dout;
	assign serial_data_oe  = st.oe;
	// idle converter shows as low power
	assign low_power       = (st.conv == adc_readout_pkg::CONV_SLEEP);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_st        = st;
		next_st.cs_s1  = cs_n_pin;
		next_st.cs_s2  = st.cs_s1;
		next_st.cs_s3  = st.cs_s2;
		next_st.sck_s1 = serial_shift_clock_in;
		next_st.sck_s2 = st.sck_s1;
		next_st.sck_s3 = st.sck_s2;

		// conversion core
		if (cs_fall) begin
			next_st.conv    = adc_readout_pkg::CONV_RUN;
			next_st.div     = 8'h00;
			next_st.bit_idx = BW'(RES_W - 1);
			next_st.result  = '0;
			// an empty buffer leaves the previous level held
			if (fifo_valid) begin
				next_st.sample = $signed(fifo_data);
			end
		end else if (st.conv == adc_readout_pkg::CONV_RUN) begin
			next_st.div = conv_tick ? 8'h00 : st.div + 8'h01;
			if (conv_tick) begin
				next_st.result = sar_step(st.result, st.bit_idx, st.sample);
				if (st.bit_idx == '0) begin
					next_st.conv = adc_readout_pkg::CONV_SLEEP;
				end else begin
					next_st.bit_idx = st.bit_idx - 1'b1;
				end
			end
		end

		// serial side
		// data holds between falls
		if (!cs_low) begin
			next_st.oe   = 1'b0;
			next_st.dout = 1'b0;
		end else if (cs_fall) begin
			// new frame
			next_st.falls = 5'h00;
			next_st.oe    = 1'b0;
			next_st.dout  = 1'b0;
		end else if (sck_fall) begin
			// move only on serial clock falls
			if (st.falls != `ARO_FALL_MAX) begin
				next_st.falls = st.falls + 5'h01;
			end
			if (st.falls + 5'h01 == `ARO_ENABLE_FALL) begin
				next_st.oe    = 1'b1;
				next_st.dout  = 1'b0;
				next_st.shift = st.result;
			end else if (st.falls >= `ARO_ENABLE_FALL) begin
				// msb first, zeros after the last bit
				next_st.dout  = st.shift[RES_W-1];
				next_st.shift = {st.shift[RES_W-2:0], 1'b0};
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions

	// one trial step per divider period, sixteen steps at the default width
	localparam int CONV_MIN = RES_W * CONV_DIV;  // exact conversion length
	localparam int CONV_MAX = RES_W * CONV_DIV;

	// helper: the fifth fall of a frame
	logic fifth_fall;
	assign fifth_fall = cs_low && !cs_fall && sck_fall
		&& (st.falls + 5'h01 == `ARO_ENABLE_FALL);

	a_conv_start: assert property (
		@(posedge sys_clk) disable iff (reset)
		cs_fall |=> (st.conv == adc_readout_pkg::CONV_RUN) && (st.result == '0)
	) else $error("conversion did not start on select fall");

	a_oe_at_fifth: assert property (
		@(posedge sys_clk) disable iff (reset)
		$rose(serial_data_oe) |-> ($past(fifth_fall) && !serial_data_out)
	) else $error("output enabled off the fifth fall or not low");

	a_msb_first: assert property (
		@(posedge sys_clk) disable iff (reset)
		(cs_low && !cs_fall && sck_fall && st.falls == `ARO_ENABLE_FALL)
		|=> serial_data_out == $past(st.shift[RES_W-1])
	) else $error("first data bit is not the msb");

	a_bit_steady: assert property (
		@(posedge sys_clk) disable iff (reset)
		(sck_rise && cs_low && !cs_fall) |=> $stable(serial_data_out)
	) else $error("data moved on a rising serial clock edge");

	a_conv_sleeps: assert property (
		@(posedge sys_clk) disable iff (reset)
		(conv_tick && st.bit_idx == '0 && !cs_fall) |=> low_power
	) else $error("converter did not sleep after last step");

	a_dout_on_fall: assert property (
		@(posedge sys_clk) disable iff (reset)
		($changed(serial_data_out) && cs_low) |-> $past(sck_fall || cs_fall)
	) else $error("data changed without a serial clock fall");

	a_overrange_clamp: assert property (
		@(posedge sys_clk) disable iff (reset)
		($rose(low_power) && st.sample > $signed(LEVEL_W'({RES_W{1'b1}})))
		|-> st.result == {RES_W{1'b1}}
	) else $error("overrange level did not give all ones");

	a_underrange_zero: assert property (
		@(posedge sys_clk) disable iff (reset)
		($rose(low_power) && st.sample < 0) |-> st.result == '0
	) else $error("negative level did not give all zeros");

	a_no_latency: assert property (
		@(posedge sys_clk) disable iff (reset)
		fifth_fall |-> low_power ##1 (st.shift == $past(st.result))
	) else $error("transfer loaded a result not yet complete");

	a_conv_length: assert property (
		@(posedge sys_clk) disable iff (reset)
		cs_fall |=> !low_power ##[CONV_MIN:CONV_MAX] $rose(low_power)
	) else $error("conversion length out of bounds");

	a_release_high: assert property (
		@(posedge sys_clk) disable iff (reset)
		st.cs_s2 |=> !serial_data_oe
	) else $error("output driven while deselected");

	c_frame_start: cover property (@(posedge sys_clk) disable iff (reset) cs_fall);
	c_output_on: cover property (@(posedge sys_clk) disable iff (reset) $rose(serial_data_oe));
	c_full_frame: cover property (@(posedge sys_clk) disable iff (reset)
		cs_low && st.falls == 5'h15);
	c_buffer_full: cover property (@(posedge sys_clk) disable iff (reset) !level_ready);
endmodule

/* File: testbench/host_model.sv */
`timescale 1ns/1ps
// host side of the serial link: drives select and shift clock, captures the result
module host_model (
	output logic      cs_n_pin,
	output logic      serial_shift_clock_in,
	input  wire logic serial_data_out,
	input  wire logic serial_data_oe,
	input  wire logic low_power
);
	logic        pin;       // resolved level of the data line
	logic [15:0] rise_word; // bits captured on rising edges
	logic [15:0] fall_word; // bits captured just before falling edges
	logic        lead;      // leading bit after output enable
	logic        early_oe;  // line seen driven before the fifth fall
	logic        awake;     // converter seen running after select fall
	logic        asleep;    // converter seen asleep before data phase
	logic        freed;     // line seen released after select rises
	// no pull on the line, so an undriven pin reads z and never a stale bit
	assign pin = serial_data_oe ? serial_data_out : 1'bz;
	// clock stands still high between frames
	initial begin
		cs_n_pin = 1'b1;
		serial_shift_clock_in = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// one frame: select low, 21 falls at 125 ns, then select high
	task automatic frame();
		early_oe = 1'b0;
		// offset keeps link edges away from sys_clk edges
		#1.3;
		cs_n_pin = 1'b0;
		#60;
		awake = !low_power;
		for (int k = 1; k <= 21; k++) begin
			#62;
			if (k <= 5 && serial_data_oe !== 1'b0) begin
				early_oe = 1'b1;
			end
			if (k == 5) begin
				asleep = low_power;
			end
			// previous bit must still stand right before this fall
			if (k >= 7) begin
				fall_word = {fall_word[14:0], pin};
			end
			#0.5 serial_shift_clock_in = 1'b0;
			#62.5 serial_shift_clock_in = 1'b1;
			if (k == 5) begin
				lead = pin;
			end else if (k >= 6) begin
				rise_word = {rise_word[14:0], pin};
			end
		end
		#62;
		fall_word = {fall_word[14:0], pin};
		cs_n_pin = 1'b1;
		#40;
		freed = (serial_data_oe === 1'b0);
		// idle gap lets the line settle before the next frame
		#200;
	endtask
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps
// self-checking bench: level stream in, host frames out
module tb;
	logic        sys_clk;         // 200 MHz system clock
	logic        reset;           // async, active high
	logic [17:0] level_data;      // sampled level fed to the buffer
	logic        level_valid;     // level word offered
	logic        level_ready;     // buffer accepts
	logic        low_power;       // converter asleep
	logic        cs_n_pin;        // select from host
	logic        sclk;            // host shift clock
	logic        dout;            // serial data
	logic        doe;             // serial data enable
	logic [31:0] lfsr;            // random source
	logic [15:0] exp_q[$];        // expected codes, oldest first
	logic [15:0] last_exp;        // code reused when the buffer is empty
	logic [17:0] corners [6];     // hand-picked corner levels
	int          err_count;       // mismatches
	int          samples_checked; // comparisons
	adc_serial_result_readout adc_serial_result_readout_i (
		.sys_clk(sys_clk), .reset(reset), .cs_n_pin(cs_n_pin),
		.serial_shift_clock_in(sclk), .serial_data_out(dout), .serial_data_oe(doe),
		.level_data(level_data), .level_valid(level_valid), .level_ready(level_ready),
		.low_power(low_power)
	);
	host_model host_model_i (
		.cs_n_pin(cs_n_pin), .serial_shift_clock_in(sclk), .serial_data_out(dout),
		.serial_data_oe(doe), .low_power(low_power)
	);
	////////////////////////////////////////////////////////////////////////////////
	// clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// next random value
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] code_of(input logic signed [17:0] l);
		if (l > 18'sh0_ffff) begin
			return 16'hffff;
		end else if (l < 0) begin
			return 16'h0000;
		end
		return l[15:0];
	endfunction
	// single comparison point
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// offer one word, hold it while refused; valid stays high for back to back
	task automatic push(input logic [17:0] v);
		int n;
		n = 0;
		level_data <= v;
		level_valid <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (level_ready !== 1'b1 && n < 100);
		if (n >= 100) begin
			err_count++;
			test_done();
		end
		exp_q.push_back(code_of(v));
	endtask
	// one host frame and its comparisons
	task automatic run_frame();
		logic [15:0] e;
		if (exp_q.size() > 0) begin
			last_exp = exp_q.pop_front();
		end
		e = last_exp;
		host_model_i.frame();
		check(host_model_i.rise_word, e);
		check(host_model_i.fall_word, e);
		check({15'h0000, host_model_i.lead}, 16'h0000);
		check({15'h0000, host_model_i.early_oe}, 16'h0000);
		check({15'h0000, host_model_i.awake}, 16'h0001);
		check({15'h0000, host_model_i.asleep}, 16'h0001);
		check({15'h0000, host_model_i.freed}, 16'h0001);
		@(posedge sys_clk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// watchdog against a hung run
	initial begin
		#200000;
		err_count++;
		test_done();
	end
	// main sequence
	initial begin
		reset = 1'b1;
		level_data = 18'h0_0000;
		level_valid = 1'b0;
		lfsr = 32'hce24_5079;
		last_exp = 16'h0000;
		err_count = 0;
		samples_checked = 0;
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		// corner levels: full scale, over range, below ground, midscale
		corners = '{18'h0_ffff, 18'h1_0000, 18'h3_ffff, 18'h0_0000, 18'h0_8000, 18'h2_0000};
		for (int i = 0; i < 6; i++) begin
			push(corners[i]);
			level_valid <= 1'b0;
			@(posedge sys_clk);
			run_frame();
		end
		// fill the buffer back to back with random words until it refuses
		for (int i = 0; i < 8; i++) begin
			lfsr = step(lfsr);
			push(lfsr[17:0]);
		end
		// offer a ninth word to the full buffer; it must be refused, not stored
		lfsr = step(lfsr);
		level_data <= lfsr[17:0];
		repeat (3) @(posedge sys_clk);
		level_valid <= 1'b0;
		@(posedge sys_clk);
		#1;
		check({15'h0000, level_ready}, 16'h0000);
		// drain oldest first, then one frame on the empty buffer
		repeat (9) run_frame();
		#1;
		check({15'h0000, level_ready}, 16'h0001);
		test_done();
	end
endmodule
